// >>> hdl/mxi_emif.sv
// module: external move steering and multiplexed off-chip bus sequencer
`timescale 1ns/1ns

// Notes on behaviour
// - mode 00 sends all moves on-chip, aliased
// - split modes: below 2 kB on-chip, else off
// - mode 01 high byte from port latch
// - mode 10 high byte from bank page
// - mode 11 sends every move off-chip
// - width code sets latch strobe high, low
// - width ignored unless top mode bit zero
// - low address and data share eight pins
// - device drives the address latch strobe
// - phase one: strobe high, low address out
// - data phase with rd/wr starts after the strobe low time
module mxi_emif (
  input  wire logic                        mclk,
  input  wire logic                        reset_n,
  // register port
  input  wire logic [mxi_pkg::REG_AW-1:0]  reg_addr,
  input  wire logic [mxi_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [mxi_pkg::DATA_W-1:0]  reg_rdata,
  // cpu move port
  input  wire logic                        mv_req,
  input  wire mxi_pkg::mxi_move_t          mv_cmd,
  output logic                             mv_ready,
  output logic                             mv_done,
  output logic      [mxi_pkg::DATA_W-1:0]  mv_rdata,
  output logic                             mv_offchip,
  // on-chip extended ram
  output mxi_pkg::mxi_extended_ram_t               extended_ram,
  input  wire logic [mxi_pkg::DATA_W-1:0]  extended_ram_rdata,
  // off-chip pins
  output logic                             ale,
  output logic      [mxi_pkg::DATA_W-1:0]  ad_out,
  output logic                             ad_oe,
  input  wire logic [mxi_pkg::DATA_W-1:0]  ad_in,
  output logic      [mxi_pkg::DATA_W-1:0]  addr_hi,
  output logic                             wr_n,
  output logic                             rd_n
);
  import mxi_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0]        map_mode_select;
  logic              map_mode_top_bit;
  logic [1:0]        strobe_width_select;
  logic [7:0]        bank_page_register;
  logic [7:0]        high_latch;

  mxi_state_t        state;
  mxi_state_t        next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [CNT_W-1:0]  phase_len;
  logic [CNT_W-1:0]  next_phase_len;

  logic              cur_we;
  logic [ADDR_W-1:0] cur_addr;
  logic [DATA_W-1:0] cur_wdata;
  logic              next_we;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] next_wdata;

  logic              start;
  logic [7:0]        eff_hi;
  logic [ADDR_W-1:0] eff_addr;
  logic              below_limit;
  logic              go_offchip;
  logic [1:0]        width_code;
  logic [DATA_W-1:0] ad_sync;

  // ----------------------------------------------------------------
  // register write side
  // ----------------------------------------------------------------
  // width is sampled per access, so a write mid-access only affects the next one
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      map_mode_select     <= RST_MODE;
      map_mode_top_bit    <= RST_TOP;
      strobe_width_select <= RST_WIDTH;
    end else if (reg_wr && reg_addr == OFS_EXT_MEM_CONFIG) begin
      map_mode_select     <= reg_wdata[CFG_MODE_LSB +: 2];
      map_mode_top_bit    <= reg_wdata[CFG_TOP_BIT];
      strobe_width_select <= reg_wdata[CFG_WIDTH_LSB +: 2];
    end
  end

  // bank page register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bank_page_register <= RST_BANK_PAGE;
    end else if (reg_wr && reg_addr == OFS_BANK_PAGE) begin
      bank_page_register <= reg_wdata;
    end
  end

  // high-address port output latches
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      high_latch <= RST_HIGH_LATCH;
    end else if (reg_wr && reg_addr == OFS_HIGH_LATCH) begin
      high_latch <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // register read side
  // ----------------------------------------------------------------
  // data stand one cycle after the strobe and only then; top bit reads zero
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_EXT_MEM_CONFIG: reg_rdata <= {4'h0, map_mode_select, strobe_width_select};
        OFS_BANK_PAGE:      reg_rdata <= bank_page_register;
        OFS_HIGH_LATCH:     reg_rdata <= high_latch;
        OFS_STATUS:         reg_rdata <= {6'h00, mv_offchip, (state != ST_IDLE)};
        default:            reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // address resolution and steering
  // ----------------------------------------------------------------
  // 8-bit moves borrow their upper byte; the source depends on the mode
  always_comb begin
    if (mv_cmd.wide) begin
      eff_hi = mv_cmd.addr[15:8];
    end else if (map_mode_select == MODE_SPLIT_PORT) begin
      eff_hi = high_latch;
    end else begin
      eff_hi = bank_page_register;
    end
  end

  assign eff_addr    = {eff_hi, mv_cmd.addr[7:0]};
  assign below_limit = (eff_addr < ONCHIP_LIMIT);

  // choose the target of the move
  always_comb begin
    case (map_mode_select)
      MODE_INTERNAL:   go_offchip = 1'b0;
      MODE_SPLIT_PORT: go_offchip = !below_limit;
      MODE_SPLIT_BANK: go_offchip = !below_limit;
      MODE_EXTERNAL:   go_offchip = 1'b1;
      default:         go_offchip = 1'b0;
    endcase
  end

  // a top bit of one falls back to the shortest strobe
  assign width_code = map_mode_top_bit ? WIDTH_IGNORED : strobe_width_select;

  assign mv_ready = (state == ST_IDLE);
  assign start    = mv_req && mv_ready;

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  // codes 00..11 give 1..4 cycles for both strobe levels
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_phase_len = phase_len;
    next_we        = cur_we;
    next_addr      = cur_addr;
    next_wdata     = cur_wdata;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_we        = mv_cmd.we;
          next_addr      = eff_addr;
          next_wdata     = mv_cmd.wdata;
          next_phase_len = {1'b0, width_code};
          next_cnt       = {1'b0, width_code};
          next_state     = go_offchip ? ST_ALE_HI : ST_ONCHIP;
        end
      end
      ST_ONCHIP: begin
        next_state = ST_ONWAIT;
      end
      ST_ONWAIT: begin
        next_state = ST_IDLE;
      end
      ST_ALE_HI: begin
        if (cnt == '0) begin
          next_cnt   = phase_len;
          next_state = ST_ALE_LO;
        end else begin
          next_cnt = cnt - 3'h1;
        end
      end
      ST_ALE_LO: begin
        if (cnt == '0) begin
          next_cnt   = phase_len;
          next_state = ST_STROBE;
        end else begin
          next_cnt = cnt - 3'h1;
        end
      end
      ST_STROBE: begin
        if (cnt == '0) begin
          next_cnt   = SYNC_CYC - 3'h1;
          next_state = cur_we ? ST_HOLD : ST_SETTLE;
        end else begin
          next_cnt = cnt - 3'h1;
        end
      end
      ST_SETTLE: begin
        // read strobe stays low while the pins pass the synchroniser
        if (cnt == '0) begin
          next_state = ST_HOLD;
        end else begin
          next_cnt = cnt - 3'h1;
        end
      end
      ST_HOLD: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state     <= ST_IDLE;
      cnt       <= '0;
      phase_len <= '0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      phase_len <= next_phase_len;
    end
  end

  // access held for its whole length
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cur_we    <= 1'b0;
      cur_addr  <= '0;
      cur_wdata <= '0;
    end else begin
      cur_we    <= next_we;
      cur_addr  <= next_addr;
      cur_wdata <= next_wdata;
    end
  end

  // ----------------------------------------------------------------
  // on-chip extended ram port
  // ----------------------------------------------------------------
  // mode 00 aliases the full address onto the on-chip space by truncation
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      extended_ram <= '0;
    end else begin
      extended_ram.req   <= (next_state == ST_ONCHIP);
      extended_ram.we    <= next_we;
      extended_ram.addr  <= next_addr[EXTENDED_RAM_AW-1:0];
      extended_ram.wdata <= next_wdata;
    end
  end

  // ----------------------------------------------------------------
  // off-chip pins
  // ----------------------------------------------------------------
  // pins register the next state so each edge lines up with the state change
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ale <= 1'b0;
    end else begin
      ale <= (next_state == ST_ALE_HI);
    end
  end

  // shared pins: low address in phase one, write data in phase two
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ad_out <= '0;
      ad_oe  <= 1'b0;
    end else begin
      if (next_state == ST_ALE_HI || next_state == ST_ALE_LO) begin
        ad_out <= next_addr[7:0];
        ad_oe  <= 1'b1;
      end else if (next_we && (next_state == ST_STROBE || next_state == ST_HOLD)) begin
        ad_out <= next_wdata;
        ad_oe  <= 1'b1;
      end else begin
        ad_oe  <= 1'b0;
      end
    end
  end

  // read and write strobes, only after the latch strobe has fallen
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_n <= 1'b1;
      rd_n <= 1'b1;
    end else begin
      wr_n <= !(next_we && next_state == ST_STROBE);
      rd_n <= !(!next_we && (next_state == ST_STROBE || next_state == ST_SETTLE));
    end
  end

  // upper address held on its own pins; between accesses it keeps the last value
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr_hi <= '0;
    end else if (start && go_offchip) begin
      addr_hi <= eff_addr[15:8];
    end
  end

  // ----------------------------------------------------------------
  // read data return
  // ----------------------------------------------------------------
  mxi_pin_sync u_ad_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .pin_in   (ad_in),
    .pin_sync (ad_sync)
  );

  // data taken as the read closes: pins need four edges to reach ad_sync
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mv_rdata <= '0;
    end else if (state == ST_HOLD && !cur_we) begin
      mv_rdata <= ad_sync;
    end else if (state == ST_ONWAIT && !cur_we) begin
      mv_rdata <= extended_ram_rdata;
    end
  end

  // completion pulse and target of the finished move
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mv_done    <= 1'b0;
      mv_offchip <= 1'b0;
    end else begin
      mv_done <= (state == ST_HOLD) || (state == ST_ONWAIT);
      if (start) begin
        mv_offchip <= go_offchip;
      end
    end
  end

endmodule : mxi_emif

// >>> hdl/mxi_pin_sync.sv
// module: three-stage synchroniser with agreement filter for the shared data pins
`timescale 1ns/1ns
module mxi_pin_sync (
  input  wire logic                      mclk,
  input  wire logic                      reset_n,
  input  wire logic [mxi_pkg::DATA_W-1:0] pin_in,
  output logic      [mxi_pkg::DATA_W-1:0] pin_sync
);
  import mxi_pkg::*;

  // ----------------------------------------------------------------
  // per-bit chain
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < DATA_W; b = b + 1) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      // first stage is read only by the second
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          pin_sync[b] <= 1'b0;
        end else begin
          s1 <= pin_in[b];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            pin_sync[b] <= s3; // change counts once two stages agree
          end
        end
      end
    end
  endgenerate

endmodule : mxi_pin_sync

// >>> hdl/mxi_pkg.sv
// package: constants, states and carriers of the multiplexed external memory interface
package mxi_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned EXTENDED_RAM_AW    = 11;
  localparam int unsigned REG_AW     = 2;
  localparam int unsigned CNT_W      = 3;

  // ----------------------------------------------------------------
  // register offsets on the plain register port
  // ----------------------------------------------------------------
  localparam logic [REG_AW-1:0] OFS_EXT_MEM_CONFIG = 2'h0;
  localparam logic [REG_AW-1:0] OFS_BANK_PAGE      = 2'h1;
  localparam logic [REG_AW-1:0] OFS_HIGH_LATCH     = 2'h2;
  localparam logic [REG_AW-1:0] OFS_STATUS         = 2'h3;

  // ----------------------------------------------------------------
  // ext_mem_config field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CFG_WIDTH_LSB = 0;
  localparam int unsigned CFG_MODE_LSB  = 2;
  localparam int unsigned CFG_TOP_BIT   = 4;
  localparam logic [1:0]  RST_WIDTH     = 2'h3;
  localparam logic [1:0]  RST_MODE      = 2'h0;
  localparam logic        RST_TOP       = 1'b0;
  localparam logic [7:0]  RST_BANK_PAGE = 8'h00;
  localparam logic [7:0]  RST_HIGH_LATCH = 8'hff;

  // ----------------------------------------------------------------
  // mapping modes and address map
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_INTERNAL   = 2'h0;
  localparam logic [1:0]  MODE_SPLIT_PORT = 2'h1;
  localparam logic [1:0]  MODE_SPLIT_BANK = 2'h2;
  localparam logic [1:0]  MODE_EXTERNAL   = 2'h3;
  localparam logic [ADDR_W-1:0] ONCHIP_LIMIT = 16'h0800;

  // ----------------------------------------------------------------
  // timing counts in system clock cycles
  // ----------------------------------------------------------------
  localparam logic [1:0]       WIDTH_IGNORED = 2'h0;
  localparam logic [CNT_W-1:0] SYNC_CYC      = 3'h3;

  // one-hot states of the access sequencer
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_ONCHIP = 8'h02,
    ST_ONWAIT = 8'h04,
    ST_ALE_HI = 8'h08,
    ST_ALE_LO = 8'h10,
    ST_STROBE = 8'h20,
    ST_SETTLE = 8'h40,
    ST_HOLD   = 8'h80
  } mxi_state_t;

  // external move request from the cpu
  typedef struct packed {
    logic              we;
    logic              wide;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mxi_move_t;

  // request toward the on-chip extended ram
  typedef struct packed {
    logic               req;
    logic               we;
    logic [EXTENDED_RAM_AW-1:0] addr;
    logic [DATA_W-1:0]  wdata;
  } mxi_extended_ram_t;

endpackage : mxi_pkg

// >>> testbench/mxi_emif_asserts.sv
// checker: port-level properties of the external memory interface
`timescale 1ns/1ns
module mxi_emif_asserts (
  input wire logic                       mclk,
  input wire logic                       reset_n,
  input wire logic [mxi_pkg::REG_AW-1:0] reg_addr,
  input wire logic [mxi_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       ale,
  input wire logic [mxi_pkg::DATA_W-1:0] ad_out,
  input wire logic                       ad_oe,
  input wire logic [mxi_pkg::DATA_W-1:0] addr_hi,
  input wire logic                       wr_n,
  input wire logic                       rd_n,
  input wire mxi_pkg::mxi_extended_ram_t         extended_ram
);
  import mxi_pkg::*;
  // ----------------------------------------------------------------
  // config shadow and strobe phase lengths
  // ----------------------------------------------------------------
  logic [1:0] sh_mode;
  logic [1:0] sh_width;
  logic       sh_top;
  logic       ale_q;
  logic [2:0] hi_len;
  logic [2:0] lo_len;
  logic [2:0] exp_l;
  // shadow follows config writes only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sh_mode  <= RST_MODE;
      sh_width <= RST_WIDTH;
      sh_top   <= RST_TOP;
    end else if (reg_wr && reg_addr == OFS_EXT_MEM_CONFIG) begin
      sh_mode  <= reg_wdata[CFG_MODE_LSB +: 2];
      sh_width <= reg_wdata[CFG_WIDTH_LSB +: 2];
      sh_top   <= reg_wdata[CFG_TOP_BIT];
    end
  end
  // lengths saturate so a stuck strobe cannot wrap back to a legal count
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ale_q  <= 1'b0;
      hi_len <= 3'h0;
      lo_len <= 3'h0;
    end else begin
      ale_q <= ale;
      if (ale)
        hi_len <= !ale_q ? 3'h1 : (hi_len == 3'h7 ? hi_len : hi_len + 3'h1);
      if (!ale && ale_q)
        lo_len <= 3'h1;
      else if (lo_len != 3'h7)
        lo_len <= lo_len + 3'h1;
    end
  end
  assign exp_l = sh_top ? 3'h1 : {1'b0, sh_width} + 3'h1;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_strobe_on;
    $fell(wr_n) || $fell(rd_n);
  endsequence
  sequence s_ale_fall;
    ale ##1 !ale;
  endsequence
  property p_width;
    s_strobe_on |-> (sh_top || (hi_len == exp_l && lo_len == exp_l));
  endproperty
  property p_top;
    s_strobe_on |-> (!sh_top || (hi_len == 3'h1 && lo_len == 3'h1));
  endproperty
  property p_internal;
    sh_mode == MODE_INTERNAL |-> !ale && !ad_oe;
  endproperty
  property p_external;
    sh_mode == MODE_EXTERNAL |-> !extended_ram.req;
  endproperty
  property p_addr_phase;
    ale |-> ad_oe && wr_n && rd_n;
  endproperty
  property p_latch_edge;
    s_ale_fall |-> $stable(ad_out) && $stable(addr_hi);
  endproperty
  property p_hi_hold;
    !(wr_n && rd_n) |-> $stable(addr_hi);
  endproperty
  property p_read_float;
    !rd_n |-> !ad_oe && wr_n;
  endproperty
  property p_write_drive;
    !wr_n |-> ad_oe && !ale;
  endproperty
  a_width: assert property (p_width) else $error("latch strobe width wrong");
  a_top: assert property (p_top) else $error("width not ignored");
  a_internal: assert property (p_internal) else $error("off-chip in internal mode");
  a_external: assert property (p_external) else $error("on-chip in external mode");
  a_addr_phase: assert property (p_addr_phase) else $error("address phase bad");
  a_latch_edge: assert property (p_latch_edge) else $error("address moved at fall");
  a_hi_hold: assert property (p_hi_hold) else $error("upper address moved");
  a_read_float: assert property (p_read_float) else $error("pins driven in read");
  a_write_drive: assert property (p_write_drive) else $error("write data not out");
endmodule : mxi_emif_asserts

// >>> testbench/mxi_emif_tb_top.sv
// testbench: directed scenarios for the external memory interface
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module mxi_emif_tb_top;
  import mxi_pkg::*;
  logic       mclk, reset_n, reg_wr, reg_rd, mv_req, mv_ready, mv_done, mv_offchip;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, mv_rdata, ad_out, ad_in, addr_hi, extended_ram_rdata;
  logic       ale, ad_oe, wr_n, rd_n;
  mxi_move_t  mv_cmd;
  mxi_extended_ram_t  extended_ram;
  int         err_count, cmp_count, cyc_count;
  logic [7:0] iram [0:2047];
  logic [7:0] v;
  mxi_emif dut (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .mv_req, .mv_cmd, .mv_ready, .mv_done, .mv_rdata, .mv_offchip, .extended_ram, .extended_ram_rdata,
    .ale, .ad_out, .ad_oe, .ad_in, .addr_hi, .wr_n, .rd_n);
  mxi_ext_sram u_sram (.mclk, .ale, .ad_out, .ad_oe, .addr_hi, .wr_n, .rd_n, .ad_in);
  // ----------------------------------------------------------------
  // clock, on-chip ram, hang guard
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // on-chip ram answers the cycle after a request
  always @(posedge mclk) begin
    if (extended_ram.req) begin
      if (extended_ram.we) iram[extended_ram.addr] <= extended_ram.wdata;
      extended_ram_rdata <= iram[extended_ram.addr];
    end
  end
  // whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc_count++;
    if (cyc_count == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic reg_wr_t(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_wr_t
  // read data stand only in the cycle after the strobe
  task automatic reg_rd_t(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_rd_t
  task automatic cfg(input logic [1:0] m, input logic [1:0] w, input logic t);
    reg_wr_t(OFS_EXT_MEM_CONFIG, {3'h0, t, m, w});
  endtask : cfg
  // one move, counting cycles from the take edge to the done pulse
  task automatic mv_chk(input logic we, input logic wide, input logic [15:0] a,
                        input logic [7:0] d, input int en);
    int n;
    @(posedge mclk);
    mv_req <= 1'b1;
    mv_cmd <= {we, wide, a, d};
    @(posedge mclk);
    mv_req <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (mv_done !== 1'b1 && n < 40);
    `CHK("move cycles", en, n)
    if (!we) `CHK("move data", d, mv_rdata)
  endtask : mv_chk
  task automatic t_regs();
    reg_rd_t(OFS_EXT_MEM_CONFIG, v);
    `CHK("config reset", 8'h03, v)
    reg_rd_t(OFS_BANK_PAGE, v);
    `CHK("bank reset", 8'h00, v)
    reg_rd_t(OFS_HIGH_LATCH, v);
    `CHK("latch reset", 8'hff, v)
    reg_wr_t(OFS_EXT_MEM_CONFIG, 8'hfe);
    reg_rd_t(OFS_EXT_MEM_CONFIG, v);
    `CHK("config rw", 8'h0e, v)
  endtask : t_regs
  task automatic t_internal();
    cfg(MODE_INTERNAL, 2'h0, 1'b0);
    mv_chk(1'b1, 1'b1, 16'h1234, 8'ha5, 2);
    mv_chk(1'b0, 1'b1, 16'h0234, 8'ha5, 2);
    mv_chk(1'b0, 1'b1, 16'hfa34, 8'ha5, 2);
    `CHK("target", 1'b0, mv_offchip)
  endtask : t_internal
  // both split modes at the last on-chip and first off-chip address
  task automatic t_split();
    for (int m = 1; m <= 2; m++) begin
      cfg(m[1:0], 2'h0, 1'b0);
      mv_chk(1'b1, 1'b1, 16'h07ff, 8'h3c, 2);
      mv_chk(1'b0, 1'b1, 16'h07ff, 8'h3c, 2);
      mv_chk(1'b1, 1'b1, 16'h0800, 8'hc3, 4);
      mv_chk(1'b0, 1'b1, 16'h0800, 8'hc3, 7);
      `CHK("target", 1'b1, mv_offchip)
      reg_rd_t(OFS_STATUS, v);
      `CHK("status", 8'h02, v)
    end
  endtask : t_split
  // external mode: low addresses must still go off-chip, every width code
  task automatic t_widths();
    for (int w = 0; w < 4; w++) begin
      cfg(MODE_EXTERNAL, w[1:0], 1'b0);
      mv_chk(1'b1, 1'b1, 16'h0120 + w[15:0], 8'h5a ^ w[7:0], 3 * (w + 1) + 1);
      mv_chk(1'b0, 1'b1, 16'h0120 + w[15:0], 8'h5a ^ w[7:0], 3 * (w + 1) + 4);
    end
  endtask : t_widths
  task automatic t_top();
    cfg(MODE_EXTERNAL, 2'h3, 1'b1);
    mv_chk(1'b1, 1'b1, 16'h0456, 8'h77, 4);
    mv_chk(1'b0, 1'b1, 16'h0456, 8'h77, 7);
  endtask : t_top
  // 8-bit moves: upper byte from the port latch, then from the bank page
  task automatic t_eight();
    cfg(MODE_SPLIT_PORT, 2'h1, 1'b0);
    // bank page differs from the port latch so a wrong source lands elsewhere
    reg_wr_t(OFS_BANK_PAGE, 8'h50);
    reg_wr_t(OFS_HIGH_LATCH, 8'h40);
    mv_chk(1'b1, 1'b0, 16'h0055, 8'h9e, 7);
    mv_chk(1'b0, 1'b1, 16'h4055, 8'h9e, 10);
    cfg(MODE_SPLIT_BANK, 2'h1, 1'b0);
    reg_wr_t(OFS_BANK_PAGE, 8'h60);
    mv_chk(1'b1, 1'b0, 16'h0066, 8'he1, 7);
    mv_chk(1'b0, 1'b1, 16'h6066, 8'he1, 10);
  endtask : t_eight
  initial begin
    reset_n = 1'b0;
    {reg_wr, reg_rd, mv_req, reg_addr, reg_wdata} = '0;
    mv_cmd = '0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    t_regs();
    t_internal();
    t_split();
    t_widths();
    t_top();
    t_eight();
    tally_and_finish();
  end
endmodule : mxi_emif_tb_top
bind mxi_emif mxi_emif_asserts u_chk (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
  .ale, .ad_out, .ad_oe, .addr_hi, .wr_n, .rd_n, .extended_ram);

// >>> testbench/mxi_ext_sram.sv
// partner: transparent address latch in front of an asynchronous sram
`timescale 1ns/1ns
module mxi_ext_sram (
  input  wire logic       mclk,
  input  wire logic       ale,
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe,
  input  wire logic [7:0] addr_hi,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  output logic      [7:0] ad_in
);
  logic [7:0] lat_lo;
  logic [7:0] last;
  logic [7:0] mem [0:65535];
  // latch follows the shared pins while the strobe is high, frozen from its fall
  always_latch begin
    if (ale) lat_lo <= ad_out;
  end
  // write lands as the write strobe ends
  always @(posedge wr_n) begin
    mem[{addr_hi, lat_lo}] <= ad_out;
  end
  // released pins show the inverse of the last level so a float never reads as data
  assign ad_in = ad_oe ? ad_out : (!rd_n ? mem[{addr_hi, lat_lo}] : ~last);
  always @(posedge mclk) begin
    last <= ad_in;
  end
endmodule : mxi_ext_sram
